/* verilog/mtp_manual_ctrl.sv */
// Purpose: manual mode panel control and tuning-carrier handshake
// Assumes: panel inputs and tune request are asynchronous active-high levels
// Notes:   action outputs are one-cycle pulses from flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "mtp_consts.svh"
module mtp_manual_ctrl #(
  parameter logic [`MTP_CNT_W-1:0] SHORT_MAX = `MTP_CNT_W'(`MTP_SHORT_MAX_CYC),
  parameter logic [`MTP_CNT_W-1:0] MED_MIN   = `MTP_CNT_W'(`MTP_MED_MIN_CYC),
  parameter logic [`MTP_CNT_W-1:0] MED_MAX   = `MTP_CNT_W'(`MTP_MED_MAX_CYC),
  parameter logic [`MTP_CNT_W-1:0] LONG_MIN  = `MTP_CNT_W'(`MTP_LONG_MIN_CYC)
) (
  input  wire logic                    clock_in,
  input  wire logic                    reset_n_in,
  input  wire logic                    manual_mode_in,
  input  wire logic [`MTP_RADIO_W-1:0] radio_type_in,
  input  wire logic                    ant_switch_cfg_in,
  input  wire logic                    mode_btn_in,
  input  wire logic                    knob_btn_in,
  input  wire logic                    out_btn_in,
  input  wire logic                    knob_cw_in,
  input  wire logic                    knob_ccw_in,
  input  wire logic                    tune_req_in,
  output logic                         carrier_on_out,
  output logic                         sel_bypass_out,
  output logic                         ind_active_out,
  output logic                         step_up_out,
  output logic                         step_dn_out,
  output logic                         ind_spin_out,
  output logic                         cap_home_out,
  output logic                         ind_home_out,
  output logic                         balanced_out,
  output logic                         ant_menu_out
);
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_ff;
  logic [NSYNC-1:0] s2_ff;
  logic [2:0]       edge_d_ff;
  logic             req_rise;
  logic             hs_ok;

  assign raw = {tune_req_in, knob_ccw_in, knob_cw_in, out_btn_in, knob_btn_in, mode_btn_in};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
        end else begin
          s1_ff[g] <= raw[g];
          s2_ff[g] <= s1_ff[g];
        end
      end
    end
  endgenerate

  // previous synchronised level of the edge-triggered lines: cw, ccw, tune request
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      edge_d_ff <= 3'h0;
    end else begin
      edge_d_ff <= s2_ff[5:3];
    end
  end

  mtp_press_if mode_p ();
  mtp_press_if knob_p ();
  mtp_press_if out_p ();

  mtp_press_timer #(.SHORT_MAX(SHORT_MAX), .MED_MIN(MED_MIN), .MED_MAX(MED_MAX), .LONG_MIN(LONG_MIN))
    u_mode (.clock_in(clock_in), .reset_n_in(reset_n_in), .btn_in(s2_ff[0]), .res(mode_p));
  mtp_press_timer #(.SHORT_MAX(SHORT_MAX), .MED_MIN(MED_MIN), .MED_MAX(MED_MAX), .LONG_MIN(LONG_MIN))
    u_knob (.clock_in(clock_in), .reset_n_in(reset_n_in), .btn_in(s2_ff[1]), .res(knob_p));
  mtp_press_timer #(.SHORT_MAX(SHORT_MAX), .MED_MIN(MED_MIN), .MED_MAX(MED_MAX), .LONG_MIN(LONG_MIN))
    u_out (.clock_in(clock_in), .reset_n_in(reset_n_in), .btn_in(s2_ff[2]), .res(out_p));

  function automatic logic is_cls(input logic done, input mtp_pkg::mtp_press_t c,
                                  input mtp_pkg::mtp_press_t want);
    is_cls = done && (c == want);
  endfunction

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur && !prev;
  endfunction

  assign req_rise = rise(s2_ff[5], edge_d_ff[2]);
  assign hs_ok    = manual_mode_in &&
                    (radio_type_in == `MTP_RADIO_FAM_A || radio_type_in == `MTP_RADIO_FAM_B);

  logic carrier_ff;
  logic bypass_ff;
  logic ind_ff;
  logic up_ff;
  logic dn_ff;
  logic spin_ff;
  logic chome_ff;
  logic ihome_ff;
  logic bal_ff;
  logic menu_ff;
  logic out_med;
  logic knob_short;
  logic knob_med;
  logic knob_long;
  logic out_short;

  assign out_med    = is_cls(out_p.done, out_p.cls, mtp_pkg::MTP_PR_MED);
  assign out_short  = is_cls(out_p.done, out_p.cls, mtp_pkg::MTP_PR_SHORT);
  assign knob_short = is_cls(knob_p.done, knob_p.cls, mtp_pkg::MTP_PR_SHORT);
  assign knob_med   = is_cls(knob_p.done, knob_p.cls, mtp_pkg::MTP_PR_MED);
  assign knob_long  = is_cls(knob_p.done, knob_p.cls, mtp_pkg::MTP_PR_LONG);

  // tuning carrier: request or medium output press toggles it
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      carrier_ff <= 1'b0;
    end else if (!hs_ok) begin
      carrier_ff <= 1'b0;
    end else if (req_rise || out_med) begin
      carrier_ff <= !carrier_ff;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      bypass_ff <= 1'b0;
    end else begin
      bypass_ff <= manual_mode_in && is_cls(mode_p.done, mode_p.cls, mtp_pkg::MTP_PR_SHORT);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ind_ff <= 1'b0;
    end else if (manual_mode_in && knob_short) begin
      ind_ff <= !ind_ff;
    end
  end

  // rotation pulses on synchronised edges of the encoder direction lines
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      up_ff <= 1'b0;
      dn_ff <= 1'b0;
    end else begin
      up_ff <= manual_mode_in && rise(s2_ff[3], edge_d_ff[0]);
      dn_ff <= manual_mode_in && rise(s2_ff[4], edge_d_ff[1]);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      spin_ff  <= 1'b0;
      chome_ff <= 1'b0;
      ihome_ff <= 1'b0;
    end else begin
      spin_ff  <= manual_mode_in && knob_med && ind_ff;
      chome_ff <= manual_mode_in && knob_med && !ind_ff;
      ihome_ff <= manual_mode_in && knob_long && ind_ff;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      bal_ff  <= 1'b0;
      menu_ff <= 1'b0;
    end else begin
      menu_ff <= manual_mode_in && out_short && ant_switch_cfg_in;
      if (manual_mode_in && out_short && !ant_switch_cfg_in) begin
        bal_ff <= !bal_ff;
      end
    end
  end

  assign carrier_on_out = carrier_ff;
  assign sel_bypass_out = bypass_ff;
  assign ind_active_out = ind_ff;
  assign step_up_out    = up_ff;
  assign step_dn_out    = dn_ff;
  assign ind_spin_out   = spin_ff;
  assign cap_home_out   = chome_ff;
  assign ind_home_out   = ihome_ff;
  assign balanced_out   = bal_ff;
  assign ant_menu_out   = menu_ff;

  AST_CARRIER_ON: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (hs_ok && req_rise && !out_med && !carrier_ff) |=> carrier_ff)
    else $error("tune request did not start carrier");
  AST_CARRIER_OFF: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (hs_ok && out_med && !req_rise && carrier_ff) |=> !carrier_ff)
    else $error("medium output press did not stop carrier");
  AST_UNSUPPORTED: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (!hs_ok) |=> !carrier_ff)
    else $error("carrier on with unsupported radio");
  AST_TOGGLE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (hs_ok && out_med && !req_rise) |=> (carrier_ff != $past(carrier_ff)))
    else $error("medium output press failed to toggle carrier");
  AST_BYPASS: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (bypass_ff) |-> $past(manual_mode_in) && $past(mode_p.done) && $past(mode_p.cls) == mtp_pkg::MTP_PR_SHORT)
    else $error("bypass selected without short mode press");
  AST_SWAP: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (manual_mode_in && knob_short) |=> (ind_ff != $past(ind_ff)))
    else $error("short knob press did not swap element");
  AST_MED_KNOB: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (manual_mode_in && knob_med) |=> (spin_ff == $past(ind_ff)) && (chome_ff == !$past(ind_ff)))
    else $error("medium knob press wrong action");
  AST_LONG_KNOB: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ihome_ff) |-> $past(ind_ff) && $past(knob_long) && $past(manual_mode_in) && !chome_ff)
    else $error("inductor home without inductor active");
  AST_OUTPUT: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (manual_mode_in && out_short) |=>
      ($past(ant_switch_cfg_in) ? (menu_ff && bal_ff == $past(bal_ff)) : (!menu_ff && bal_ff != $past(bal_ff))))
    else $error("short output press wrong action");
  AST_ROTATE_UP: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (manual_mode_in && s2_ff[3] && !edge_d_ff[0]) |=> up_ff)
    else $error("clockwise step did not raise position");
  AST_ROTATE_DN: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (manual_mode_in && s2_ff[4] && !edge_d_ff[1]) |=> dn_ff)
    else $error("counter-clockwise step did not lower position");
  AST_NOT_MANUAL: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (!manual_mode_in) |=> !(bypass_ff || up_ff || dn_ff || spin_ff || chome_ff || ihome_ff || menu_ff))
    else $error("panel action outside manual mode");
endmodule // mtp_manual_ctrl
`default_nettype wire

/* verilog/mtp_consts.svh */
// Purpose: timing counts and encodings for the manual tune panel control
// Assumes: 20 MHz clock
// Notes:   durations in ms, cycle counts derived from the clock rate
`ifndef MTP_CONSTS_SVH
`define MTP_CONSTS_SVH
`define MTP_CLK_HZ        20000000
`define MTP_SHORT_MAX_MS  1000
`define MTP_MED_MIN_MS    2000
`define MTP_MED_MAX_MS    3000
`define MTP_LONG_MIN_MS   10000
`define MTP_CYC_PER_MS    (`MTP_CLK_HZ / 1000)
`define MTP_SHORT_MAX_CYC (`MTP_SHORT_MAX_MS * `MTP_CYC_PER_MS)
`define MTP_MED_MIN_CYC   (`MTP_MED_MIN_MS * `MTP_CYC_PER_MS)
`define MTP_MED_MAX_CYC   (`MTP_MED_MAX_MS * `MTP_CYC_PER_MS)
`define MTP_LONG_MIN_CYC  (`MTP_LONG_MIN_MS * `MTP_CYC_PER_MS)
`define MTP_CNT_W         28
`define MTP_POS_W         8
`define MTP_RADIO_W       3
`define MTP_RADIO_FAM_A   3'h1
`define MTP_RADIO_FAM_B   3'h2
`endif

/* verilog/mtp_pkg.sv */
// Purpose: shared types for the manual tune panel control
// Assumes: nothing
// Notes:   press classes produced by the press timer
`default_nettype none
package mtp_pkg;
  typedef enum logic [1:0] {
    MTP_PR_NONE  = 2'h0,
    MTP_PR_SHORT = 2'h1,
    MTP_PR_MED   = 2'h2,
    MTP_PR_LONG  = 2'h3
  } mtp_press_t;
endpackage
`default_nettype wire

/* verilog/mtp_press_if.sv */
// Purpose: press timer result bundle
// Assumes: single clock
// Notes:   class is valid for one cycle when done is high
`timescale 1ns/1ps
`default_nettype none
interface mtp_press_if;
  logic               done;
  mtp_pkg::mtp_press_t cls;
  modport timer (output done, output cls);
  modport user  (input done, input cls);
endinterface
`default_nettype wire

/* verilog/mtp_press_timer.sv */
// Purpose: measures one synchronised button from press to release
// Assumes: button level already synchronised, active high
// Notes:   classifies duration at release; gaps between bands yield no class
`timescale 1ns/1ps
`default_nettype none
`include "mtp_consts.svh"
module mtp_press_timer #(
  parameter logic [`MTP_CNT_W-1:0] SHORT_MAX = `MTP_CNT_W'(`MTP_SHORT_MAX_CYC),
  parameter logic [`MTP_CNT_W-1:0] MED_MIN   = `MTP_CNT_W'(`MTP_MED_MIN_CYC),
  parameter logic [`MTP_CNT_W-1:0] MED_MAX   = `MTP_CNT_W'(`MTP_MED_MAX_CYC),
  parameter logic [`MTP_CNT_W-1:0] LONG_MIN  = `MTP_CNT_W'(`MTP_LONG_MIN_CYC)
) (
  input  wire logic  clock_in,
  input  wire logic  reset_n_in,
  input  wire logic  btn_in,
  mtp_press_if.timer res
);
  logic                  btn_d_ff;
  logic [`MTP_CNT_W-1:0] cnt_ff;
  logic                  done_ff;
  mtp_pkg::mtp_press_t   cls_ff;
  mtp_pkg::mtp_press_t   nxt_cls;

  always_comb begin
    nxt_cls = mtp_pkg::MTP_PR_NONE;
    if (cnt_ff <= SHORT_MAX) begin
      nxt_cls = mtp_pkg::MTP_PR_SHORT;
    end else if (cnt_ff >= MED_MIN && cnt_ff <= MED_MAX) begin
      nxt_cls = mtp_pkg::MTP_PR_MED;
    end else if (cnt_ff >= LONG_MIN) begin
      nxt_cls = mtp_pkg::MTP_PR_LONG;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      btn_d_ff <= 1'b0;
    end else begin
      btn_d_ff <= btn_in;
    end
  end

  // saturating hold counter, loaded with 1 at press
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cnt_ff <= '0;
    end else if (btn_in && !btn_d_ff) begin
      cnt_ff <= `MTP_CNT_W'(1);
    end else if (btn_in && cnt_ff != '1) begin
      cnt_ff <= cnt_ff + `MTP_CNT_W'(1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      done_ff <= 1'b0;
      cls_ff  <= mtp_pkg::MTP_PR_NONE;
    end else begin
      done_ff <= !btn_in && btn_d_ff;
      cls_ff  <= nxt_cls;
    end
  end

  assign res.done = done_ff;
  assign res.cls  = cls_ff;

  AST_GAP_IGNORED: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (!btn_in && btn_d_ff && cnt_ff > SHORT_MAX && cnt_ff < MED_MIN) |=> (cls_ff == mtp_pkg::MTP_PR_NONE))
    else $error("press between short and medium bands was classified");
endmodule // mtp_press_timer
`default_nettype wire

/* dv/mtp_xcvr_model.sv */
// Purpose: transceiver model that raises tune requests on the handshake line
// Assumes: shares the panel control clock
// Notes:   request line falls HOLD cycles after the radio button goes idle
`timescale 1ns/1ps
`default_nettype none
module mtp_xcvr_model #(
  parameter int HOLD = 4
) (
  input  wire logic clock_in,
  input  wire logic tuner_press_in,
  output logic      tune_req_out
);
  int cnt = 0;

  // each radio button press gives one rising edge, held HOLD cycles
  always @(posedge clock_in) begin
    if (tuner_press_in) begin
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  assign tune_req_out = (cnt > 0);
endmodule // mtp_xcvr_model
`default_nettype wire

/* dv/test_manual_tune_panel_control.sv */
// Purpose: self-checking bench for the manual tune panel control
// Assumes: press bands shortened to 10, 20, 30 and 100 cycles
// Notes:   pulse bits 0..6: bypass, up, down, spin, cap home, ind home, menu
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module test_manual_tune_panel_control;
  logic       clock_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       manual_mode_in = 1'b0;
  logic [2:0] radio_type_in = 3'h0;
  logic       ant_switch_cfg_in = 1'b0;
  logic [4:0] btn = 5'h00;
  logic       tuner_press = 1'b0;
  wire        tune_req;
  wire        carrier_on_out, balanced_out, ind_active_out;
  wire  [6:0] pulses;
  int         pcnt [7];
  int         n_mismatch = 0;
  int         comparisons = 0;
  int         cyc = 0;

  mtp_manual_ctrl #(.SHORT_MAX(28'h000000a), .MED_MIN(28'h0000014), .MED_MAX(28'h000001e),
    .LONG_MIN(28'h0000064)) mtp_manual_ctrl_i (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .manual_mode_in(manual_mode_in),
    .radio_type_in(radio_type_in), .ant_switch_cfg_in(ant_switch_cfg_in),
    .mode_btn_in(btn[0]), .knob_btn_in(btn[1]), .out_btn_in(btn[2]), .knob_cw_in(btn[3]),
    .knob_ccw_in(btn[4]), .tune_req_in(tune_req), .carrier_on_out(carrier_on_out),
    .sel_bypass_out(pulses[0]), .ind_active_out(ind_active_out), .step_up_out(pulses[1]),
    .step_dn_out(pulses[2]), .ind_spin_out(pulses[3]), .cap_home_out(pulses[4]),
    .ind_home_out(pulses[5]), .balanced_out(balanced_out), .ant_menu_out(pulses[6]));

  mtp_xcvr_model mtp_xcvr_model_i (
    .clock_in(clock_in), .tuner_press_in(tuner_press), .tune_req_out(tune_req));

  initial begin
    forever #25 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    for (int i = 0; i < 7; i++) pcnt[i] <= pcnt[i] + int'(pulses[i]);
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hold one panel input n cycles, then report which pulse outputs fired
  task automatic act(input int which, input int n, output logic [6:0] got);
    int snap [7];
    snap = pcnt;
    @(posedge clock_in);
    btn[which] <= 1'b1;
    repeat (n) @(posedge clock_in);
    btn[which] <= 1'b0;
    repeat (12) @(posedge clock_in);
    @(negedge clock_in);
    for (int i = 0; i < 7; i++) got[i] = (pcnt[i] != snap[i]);
  endtask

  task automatic xreq();
    @(posedge clock_in);
    tuner_press <= 1'b1;
    @(posedge clock_in);
    tuner_press <= 1'b0;
    repeat (12) @(posedge clock_in);
    @(negedge clock_in);
  endtask

  task automatic t_mode();
    logic [6:0] g;
    act(0, 5, g);   `CHK(g, 7'h01)
    act(0, 25, g);  `CHK(g, 7'h00)
    act(0, 110, g); `CHK(g, 7'h00)
    act(0, 15, g);  `CHK(g, 7'h00)
    act(1, 50, g);  `CHK(g, 7'h00)
    @(posedge clock_in) manual_mode_in <= 1'b0;
    act(0, 5, g);   `CHK(g, 7'h00)
    @(posedge clock_in) manual_mode_in <= 1'b1;
  endtask

  task automatic t_knob();
    logic [6:0] g;
    act(1, 5, g);   `CHK(ind_active_out, 1'b1)
    act(3, 2, g);   `CHK(g, 7'h02)
    act(4, 2, g);   `CHK(g, 7'h04)
    act(1, 25, g);  `CHK(g, 7'h08)
    act(1, 110, g); `CHK(g, 7'h20)
    act(1, 5, g);   `CHK(ind_active_out, 1'b0)
    act(1, 25, g);  `CHK(g, 7'h10)
    act(1, 110, g); `CHK(g, 7'h00)
  endtask

  task automatic t_out();
    logic [6:0] g;
    act(2, 5, g); `CHK({g, balanced_out}, 8'h01)
    act(2, 5, g); `CHK(balanced_out, 1'b0)
    @(posedge clock_in) ant_switch_cfg_in <= 1'b1;
    act(2, 5, g); `CHK({g, balanced_out}, 8'h80)
    @(posedge clock_in) ant_switch_cfg_in <= 1'b0;
  endtask

  task automatic t_carrier();
    logic [6:0] g;
    for (int r = 1; r <= 3; r++) begin
      @(posedge clock_in) radio_type_in <= 3'(r);
      xreq();        `CHK(carrier_on_out, (r < 3))
      xreq();        `CHK(carrier_on_out, 1'b0)
      act(2, 25, g); `CHK(carrier_on_out, (r < 3))
      act(2, 25, g); `CHK(carrier_on_out, 1'b0)
    end
  endtask

  // leave manual mode with state set, then reset mid-run
  task automatic t_reset();
    logic [6:0] g;
    @(posedge clock_in) radio_type_in <= 3'h1;
    xreq();       `CHK(carrier_on_out, 1'b1)
    act(2, 5, g); `CHK(balanced_out, 1'b1)
    act(1, 5, g); `CHK(ind_active_out, 1'b1)
    @(posedge clock_in) manual_mode_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
    `CHK(carrier_on_out, 1'b0)
    act(1, 5, g); `CHK({g, ind_active_out}, 8'h01)
    act(2, 5, g); `CHK({g, balanced_out}, 8'h01)
    @(posedge clock_in) manual_mode_in <= 1'b1;
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(negedge clock_in);
    `CHK({carrier_on_out, balanced_out, ind_active_out, pulses}, 10'h000)
  endtask

  initial begin
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    manual_mode_in <= 1'b1;
    @(negedge clock_in);
    `CHK({carrier_on_out, balanced_out, ind_active_out, pulses}, 10'h000)
    t_mode();
    t_knob();
    t_out();
    t_carrier();
    t_reset();
    end_sim();
  end
endmodule // test_manual_tune_panel_control
`default_nettype wire
